// >>> logic/sfr_host_end.sv
// Purpose: host controller issuing read commands over the serial link
// Assumes: one request at a time; len_i is at least one byte
// Notes: link clock is the host clock divided by four, idle low
`timescale 1ns/1ps
module sfr_host_end #(
	parameter int LEN_W = 16
) (
	sfr_link_if.host link,
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic [7:0] op_i,
	input wire logic [sfr_pkg::SFR_ADDR_BITS-1:0] addr_i,
	input wire logic [7:0] mode_i,
	input wire logic [LEN_W-1:0] len_i,
	input wire logic hold_req_i,
	output logic ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic done_o,
	output logic cont_mode_o
);
	import sfr_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	sfr_host_st_t st_q;
	logic [1:0] ph_q;
	logic cs_n_q;
	logic hold_n_q;
	logic [31:0] tx_q;
	logic [31:0] tx_sh;
	logic [1:0] oe_q;
	logic [7:0] op_q;
	logic [7:0] mode_q;
	logic [4:0] cnt_q;
	logic [LEN_W-1:0] left_q;
	logic [7:0] rx_q;
	logic [7:0] rx_nx;
	logic [7:0] rx_data_q;
	logic rx_valid_q;
	logic done_q;
	logic cont_q;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic run;
	logic tick;
	logic clk_end;
	logic wide_out;
	logic [4:0] byte_last;

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	assign run = (st_q != HS_IDLE) && (st_q != HS_END);
	// the clock stops low while paused, so no edge reaches the device
	assign tick = run && hold_n_q && !(hold_req_i && (ph_q == 2'h0));
	assign clk_end = tick && (ph_q == 2'h3);
	assign wide_out = sfr_wide_out(op_q);
	assign byte_last = wide_out ? {2'b00, SFR_BYTE_LAST_DUAL} : {2'b00, SFR_BYTE_LAST_SINGLE};
	assign tx_sh = oe_q[1] ? {tx_q[29:0], 2'b00} : {tx_q[30:0], 1'b0};
	assign rx_nx = wide_out ? {rx_q[5:0], sync2_q} : {rx_q[6:0], sync2_q[1]};

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= HS_IDLE;
			ph_q <= 2'h0;
			cs_n_q <= 1'b1;
			hold_n_q <= 1'b1;
			tx_q <= '0;
			oe_q <= 2'b00;
			op_q <= '0;
			mode_q <= '0;
			cnt_q <= '0;
			left_q <= '0;
			rx_q <= '0;
			rx_data_q <= '0;
			rx_valid_q <= 1'b0;
			done_q <= 1'b0;
			cont_q <= 1'b0;
			sync1_q <= 2'b11;
			sync2_q <= 2'b11;
		end else begin
			sync1_q <= link.io;
			sync2_q <= sync1_q;
			rx_valid_q <= 1'b0;
			done_q <= 1'b0;
			// divide by four keeps the link far below the normal read limit
			if (tick) begin
				ph_q <= ph_q + 2'h1;
			end
			// pause changes only while the link clock is low
			if (run && hold_n_q && hold_req_i && (ph_q == 2'h0)) begin
				hold_n_q <= 1'b0;
			end else if (!hold_n_q && !hold_req_i) begin
				hold_n_q <= 1'b1;
			end
			unique case (st_q)
				HS_IDLE: begin
					if (start_i) begin
						mode_q <= mode_i;
						left_q <= len_i;
						cs_n_q <= 1'b0;
						ph_q <= 2'h0;
						if (cont_q) begin
							op_q <= SFR_OP_DUAL_IO;
							tx_q <= {addr_i, 8'h00};
							cnt_q <= SFR_ADDR_LAST_DUAL;
							oe_q <= 2'b11;
							st_q <= HS_ADDR;
						end else begin
							op_q <= op_i;
							tx_q <= {op_i, addr_i};
							cnt_q <= SFR_CMD_LAST;
							oe_q <= 2'b01;
							st_q <= HS_CMD;
						end
					end
				end
				HS_CMD: begin
					if (clk_end) begin
						tx_q <= tx_sh;
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h00) begin
							st_q <= HS_ADDR;
							if (op_q == SFR_OP_DUAL_IO) begin
								cnt_q <= SFR_ADDR_LAST_DUAL;
								oe_q <= 2'b11;
							end else begin
								cnt_q <= SFR_ADDR_LAST_SINGLE;
							end
						end
					end
				end
				HS_ADDR: begin
					if (clk_end) begin
						tx_q <= tx_sh;
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h00) begin
							if (op_q == SFR_OP_READ) begin
								oe_q <= 2'b00;
								cnt_q <= byte_last;
								st_q <= HS_DATA;
							end else if (op_q == SFR_OP_DUAL_IO) begin
								tx_q <= {mode_q, 24'h000000};
								cnt_q <= SFR_MODE_LAST;
								st_q <= HS_MODE;
							end else begin
								tx_q <= '0;
								cnt_q <= SFR_DUMMY_LAST;
								st_q <= HS_DUMMY;
							end
						end
					end
				end
				HS_MODE: begin
					if (clk_end) begin
						tx_q <= tx_sh;
						cnt_q <= cnt_q - 5'h01;
						// low nibble is left floating to avoid a fight on the lines
						if (cnt_q == SFR_MODE_DRIVE_END) begin
							oe_q <= 2'b00;
						end
						if (cnt_q == 5'h00) begin
							cont_q <= (mode_q[7:4] == SFR_CONT_NIBBLE);
							cnt_q <= byte_last;
							st_q <= HS_DATA;
						end
					end
				end
				HS_DUMMY: begin
					if (clk_end) begin
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h00) begin
							oe_q <= 2'b00;
							cnt_q <= byte_last;
							st_q <= HS_DATA;
						end
					end
				end
				HS_DATA: begin
					if (clk_end) begin
						rx_q <= rx_nx;
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h00) begin
							rx_data_q <= rx_nx;
							rx_valid_q <= 1'b1;
							cnt_q <= byte_last;
							left_q <= left_q - 1'b1;
							if (left_q == 1) begin
								st_q <= HS_END;
							end
						end
					end
				end
				HS_END: begin
					cs_n_q <= 1'b1;
					hold_n_q <= 1'b1;
					done_q <= 1'b1;
					ph_q <= 2'h0;
					st_q <= HS_IDLE;
				end
				default: begin
					st_q <= HS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pins and user side
	// ----------------------------------------------------------------
	assign link.sck = ph_q[1];
	assign link.cs_n = cs_n_q;
	assign link.hold_n = hold_n_q;
	assign link.h_io_oe = oe_q;
	assign link.h_io_o = oe_q[1] ? tx_q[31:30] : {1'b0, tx_q[31]};
	assign ready_o = (st_q == HS_IDLE);
	assign rx_data_o = rx_data_q;
	assign rx_valid_o = rx_valid_q;
	assign done_o = done_q;
	assign cont_mode_o = cont_q;
endmodule

// >>> logic/sfr_pkg.sv
// Purpose: shared constants and types of the serial flash read path
// Assumes: host and device ends are both built from this package
// Notes: counts are last-index values; the device compares them against up-counters, the host counts down from them
package sfr_pkg;
	// ----------------------------------------------------------------
	// opcodes and mode byte
	// ----------------------------------------------------------------
	localparam logic [7:0] SFR_OP_READ = 8'h03;
	localparam logic [7:0] SFR_OP_FAST = 8'h0b;
	localparam logic [7:0] SFR_OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] SFR_OP_DUAL_IO = 8'hbb;
	localparam logic [3:0] SFR_CONT_NIBBLE = 4'ha;
	localparam int SFR_ADDR_BITS = 24;

	// ----------------------------------------------------------------
	// phase lengths in link clocks, as last index
	// ----------------------------------------------------------------
	localparam logic [4:0] SFR_CMD_LAST = 5'h07;
	localparam logic [4:0] SFR_ADDR_LAST_SINGLE = 5'h17;
	localparam logic [4:0] SFR_ADDR_LAST_DUAL = 5'h0b;
	localparam logic [4:0] SFR_MODE_LAST = 5'h03;
	localparam logic [4:0] SFR_MODE_DRIVE_END = 5'h02;
	localparam logic [4:0] SFR_DUMMY_LAST = 5'h07;
	localparam logic [2:0] SFR_BYTE_LAST_SINGLE = 3'h7;
	localparam logic [2:0] SFR_BYTE_LAST_DUAL = 3'h3;

	// ----------------------------------------------------------------
	// timing: link clock made by dividing the host clock
	// ----------------------------------------------------------------
	localparam int SFR_MCLK_HZ = 10_000_000;
	localparam int SFR_SCK_DIV = 4;
	localparam int SFR_SCK_HZ = SFR_MCLK_HZ / SFR_SCK_DIV;
	localparam int SFR_READ_MAX_HZ = 33_000_000;
	localparam int SFR_FAST_MAX_HZ = 104_000_000;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DS_CMD = 3'b000,
		DS_ADDR = 3'b001,
		DS_MODE = 3'b010,
		DS_DUMMY = 3'b011,
		DS_DATA = 3'b100,
		DS_IGNORE = 3'b101
	} sfr_dev_st_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_CMD = 3'b001,
		HS_ADDR = 3'b010,
		HS_MODE = 3'b011,
		HS_DUMMY = 3'b100,
		HS_DATA = 3'b101,
		HS_END = 3'b110
	} sfr_host_st_t;

	// ----------------------------------------------------------------
	// decoding: sfr_wide_out shared by both ends, sfr_is_read used by the device end only
	// ----------------------------------------------------------------
	function automatic logic sfr_wide_out(input logic [7:0] op);
		return (op == SFR_OP_DUAL_OUT) || (op == SFR_OP_DUAL_IO);
	endfunction

	function automatic logic sfr_is_read(input logic [7:0] op);
		return (op == SFR_OP_READ) || (op == SFR_OP_FAST) || sfr_wide_out(op);
	endfunction
endpackage

// >>> logic/sfr_link_if.sv
// Purpose: the serial link between host controller and flash device
// Assumes: host drives clock, select and pause; io lines are shared
// Notes: io resolves host first, then device, else pulled high
`timescale 1ns/1ps
interface sfr_link_if;
	logic sck;
	logic cs_n;
	logic hold_n;
	logic [1:0] h_io_o;
	logic [1:0] h_io_oe;
	logic [1:0] d_io_o;
	logic [1:0] d_io_oe;
	logic [1:0] io;

	// undriven lines read high, standing in for a pull-up
	assign io = (h_io_oe & h_io_o) | (~h_io_oe & d_io_oe & d_io_o) | (~h_io_oe & ~d_io_oe);

	modport dev (
		input sck,
		input cs_n,
		input hold_n,
		input io,
		output d_io_o,
		output d_io_oe
	);

	modport host (
		output sck,
		output cs_n,
		output hold_n,
		output h_io_o,
		output h_io_oe,
		input io
	);
endinterface

// >>> logic/sfr_dev_end.sv
// Purpose: read front end of a serial flash, clocked by the link clock
// Assumes: mem_data_i follows mem_addr_o combinationally in this domain
// Notes: select high clears the frame; continuous mode survives it
//
// Overview of operation
// - normal read 03h, no dummy, max 33MHz
// - host sends opcode then three address bytes
// - only low array address bits are decoded
// - read bytes leave on io line 1, msb first
// - address increments per byte, wraps to zero
// - input ignored after normal read address
// - raising select ends read at any time
// - normal read ignored while write in progress
// - fast read 0Bh: address, then 8 dummy clocks
// - fast read data changes on falling edges
// - pause low while clock low freezes transfer
// - pause high while clock low resumes transfer
// - paused: outputs released, inputs ignored
// - dual-io BBh: address and mode, two bits
// - mode byte Ax enters continuous read mode
// - other mode byte leaves continuous read mode
// - host releases lines during mode low nibble
// - dual-io data two bits per falling edge
// - dual-output 3Bh: serial address, dual data
// - fast and dual reads ignored while busy
// - inputs sampled msb first on rising edges
// - busy flag high while program runs
`timescale 1ns/1ps
module sfr_dev_end #(
	parameter int AW = 19
) (
	sfr_link_if.dev link,
	input wire logic nrst_i,
	input wire logic wip_i,
	input wire logic [7:0] mem_data_i,
	output logic [AW-1:0] mem_addr_o,
	output logic cont_mode_o,
	output sfr_pkg::sfr_dev_st_t phase_o
);
	import sfr_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic frame_rst_n;
	logic wip_m_q;
	logic wip_s_q;
	sfr_dev_st_t st_q;
	sfr_dev_st_t st_d;
	sfr_dev_st_t cur_st;
	logic [7:0] op_q;
	logic [7:0] op_d;
	logic [7:0] cur_op;
	logic [7:0] sr_q;
	logic [7:0] sr_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [4:0] cnt_inc;
	logic [4:0] addr_last;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] addr_d;
	logic [AW-1:0] addr_in;
	logic [2:0] dcnt_q;
	logic [2:0] dcnt_d;
	logic [2:0] byte_last;
	logic cont_q;
	logic cont_d;
	logic held_q;
	logic first_dual;
	logic wide_in;
	logic wide_out;
	logic [7:0] cmd_byte;
	logic [7:0] mode_byte;
	logic [7:0] out_q;
	logic [7:0] out_nx;
	logic drv_q;

	// ----------------------------------------------------------------
	// frame reset and busy synchroniser
	// ----------------------------------------------------------------
	// select high aborts whatever phase the frame is in
	assign frame_rst_n = nrst_i & ~link.cs_n;

	// busy comes from the program engine's domain; the link clock only
	// runs during frames, so the flag settles within the opcode
	always_ff @(posedge link.sck or negedge nrst_i) begin
		if (!nrst_i) begin
			wip_m_q <= 1'b0;
			wip_s_q <= 1'b0;
		end else begin
			wip_m_q <= wip_i;
			wip_s_q <= wip_m_q;
		end
	end

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	// in continuous mode the opcode phase is skipped
	assign first_dual = (st_q == DS_CMD) && cont_q;
	assign cur_st = first_dual ? DS_ADDR : st_q;
	assign cur_op = first_dual ? SFR_OP_DUAL_IO : op_q;
	assign wide_in = (cur_op == SFR_OP_DUAL_IO);
	assign wide_out = sfr_wide_out(op_q);
	assign cnt_inc = cnt_q + 5'h01;
	assign cmd_byte = {sr_q[6:0], link.io[0]};
	assign mode_byte = {sr_q[5:0], link.io};
	// upper address bits fall off the top of the shifter
	assign addr_in = wide_in ? {addr_q[AW-3:0], link.io} : {addr_q[AW-2:0], link.io[0]};
	assign addr_last = wide_in ? SFR_ADDR_LAST_DUAL : SFR_ADDR_LAST_SINGLE;
	assign byte_last = wide_out ? SFR_BYTE_LAST_DUAL : SFR_BYTE_LAST_SINGLE;

	// ----------------------------------------------------------------
	// rising edge sequencing
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		sr_d = sr_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		dcnt_d = dcnt_q;
		cont_d = cont_q;
		// a paused clock edge changes nothing
		if (link.hold_n) begin
			unique case (cur_st)
				DS_CMD: begin
					sr_d = cmd_byte;
					cnt_d = cnt_inc;
					if (cnt_q == SFR_CMD_LAST) begin
						cnt_d = '0;
						op_d = cmd_byte;
						// unknown opcodes and reads during a write go to the ignore state
						if (sfr_is_read(cmd_byte) && !wip_s_q) begin
							st_d = DS_ADDR;
						end else begin
							st_d = DS_IGNORE;
						end
					end
				end
				DS_ADDR: begin
					addr_d = addr_in;
					cnt_d = cnt_inc;
					if (cnt_q == addr_last) begin
						cnt_d = '0;
						op_d = cur_op;
						if (wip_s_q) begin
							st_d = DS_IGNORE;
						end else if (cur_op == SFR_OP_READ) begin
							st_d = DS_DATA;
						end else if (cur_op == SFR_OP_DUAL_IO) begin
							st_d = DS_MODE;
						end else begin
							st_d = DS_DUMMY;
						end
					end
				end
				DS_MODE: begin
					sr_d = mode_byte;
					cnt_d = cnt_inc;
					if (cnt_q == SFR_MODE_LAST) begin
						cnt_d = '0;
						cont_d = (mode_byte[7:4] == SFR_CONT_NIBBLE);
						st_d = DS_DATA;
					end
				end
				DS_DUMMY: begin
					cnt_d = cnt_inc;
					if (cnt_q == SFR_DUMMY_LAST) begin
						cnt_d = '0;
						st_d = DS_DATA;
					end
				end
				DS_DATA: begin
					// io is not looked at here, whatever the host drives
					dcnt_d = dcnt_q + 3'h1;
					if (dcnt_q == byte_last) begin
						dcnt_d = '0;
						addr_d = addr_q + 1'b1;
					end
				end
				DS_IGNORE: begin
					st_d = DS_IGNORE;
				end
				default: begin
					st_d = DS_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge link.sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			st_q <= DS_CMD;
			op_q <= '0;
			sr_q <= '0;
			cnt_q <= '0;
			addr_q <= '0;
			dcnt_q <= '0;
			held_q <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			sr_q <= sr_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			dcnt_q <= dcnt_d;
			held_q <= ~link.hold_n;
		end
	end

	// continuous mode outlives deselection; the power reset or a mode byte other than Ax clears it
	always_ff @(posedge link.sck or negedge nrst_i) begin
		if (!nrst_i) begin
			cont_q <= 1'b0;
		end else if (!link.cs_n) begin
			cont_q <= cont_d;
		end
	end

	// ----------------------------------------------------------------
	// falling edge output shifter
	// ----------------------------------------------------------------
	// a new byte is picked up when the byte counter has just wrapped
	assign out_nx = (dcnt_q == 3'h0) ? mem_data_i :
		(wide_out ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0});

	always_ff @(negedge link.sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			out_q <= '0;
			drv_q <= 1'b0;
		end else if ((st_q == DS_DATA) && !held_q) begin
			out_q <= out_nx;
			drv_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pins and user side
	// ----------------------------------------------------------------
	// pause releases the lines at once, without waiting for an edge
	assign link.d_io_oe = {drv_q & link.hold_n, drv_q & link.hold_n & wide_out};
	assign link.d_io_o = {out_q[7], wide_out & out_q[6]};
	assign mem_addr_o = addr_q;
	assign cont_mode_o = cont_q;
	assign phase_o = st_q;
endmodule

// >>> verification/sfr_link_checker.sv
// Purpose: concurrent checks on the serial link between host and device ends
// Assumes: every link signal changes only at host clock edges
// Notes: sampled on the host clock, which also makes the link clock
`timescale 1ns/1ps
module sfr_link_checker (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic wip_i,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic [1:0] h_io_o,
	input wire logic [1:0] h_io_oe,
	input wire logic [1:0] d_io_o,
	input wire logic [1:0] d_io_oe
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	// ----------------------------------------------------------------
	// helper: frame opened with the busy flag long settled
	// ----------------------------------------------------------------
	// wip is synced over two link clocks, so demand 12 host clocks of it
	logic [3:0] wip_cnt_q;
	logic [3:0] wip_cnt_d;
	logic busy_q;
	logic busy_d;
	assign wip_cnt_d = !wip_i ? 4'h0 : (wip_cnt_q == 4'hf) ? wip_cnt_q : wip_cnt_q + 4'h1;
	assign busy_d = cs_n ? (wip_cnt_q >= 4'hc) : busy_q;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wip_cnt_q <= 4'h0;
			busy_q <= 1'b0;
		end else begin
			wip_cnt_q <= wip_cnt_d;
			busy_q <= busy_d;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_unsel_quiet: assert property (cs_n |-> d_io_oe == 2'b00)
		else $error("device drives io while deselected");
	a_pause_release: assert property (!hold_n |-> d_io_oe == 2'b00)
		else $error("device drives io while paused");
	a_pause_clk_low: assert property ($fell(hold_n) |-> !sck)
		else $error("pause entered with link clock high");
	a_resume_clk_low: assert property ($rose(hold_n) |-> !sck)
		else $error("pause left with link clock high");
	a_no_contention: assert property (!cs_n |-> (h_io_oe & d_io_oe) == 2'b00)
		else $error("both ends drive one io line");
	a_dev_out_fall: assert property ((d_io_oe != 2'b00) && ($past(d_io_oe) != 2'b00)
		&& (d_io_o != $past(d_io_o)) |-> $fell(sck))
		else $error("device data changed off a falling link edge");
	a_host_out_fall: assert property ((h_io_oe != 2'b00) && ($past(h_io_oe) != 2'b00)
		&& (h_io_o != $past(h_io_o)) |-> $fell(sck))
		else $error("host data changed off a falling link edge");
	a_busy_silent: assert property (busy_q && !cs_n |-> d_io_oe == 2'b00)
		else $error("device answered a read while busy");
	a_sel_clk_idle: assert property ($fell(cs_n) |-> !sck)
		else $error("select fell with link clock high");
	// each link clock level lasts two host clocks, far below the normal read limit
	a_sck_slow: assert property ($changed(sck) |=> $stable(sck))
		else $error("link clock level shorter than two host clocks");
endmodule

// >>> verification/test_serial_flash_read_path.sv
// Purpose: self-checking bench joining the host and device ends of the link
// Assumes: memory byte is the low address byte xor 5a, array of 256 bytes
// Notes: device built with an 8-bit array so the address wrap is reached fast
`timescale 1ns/1ps
module test_serial_flash_read_path;
	import sfr_pkg::*;

	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic start_i = 1'b0;
	logic [7:0] op_i = 8'h00;
	logic [23:0] addr_i = 24'h000000;
	logic [7:0] mode_i = 8'h00;
	logic [15:0] len_i = 16'h0000;
	logic hold_req_i = 1'b0;
	logic wip_i = 1'b0;
	logic ready_o;
	logic [7:0] rx_data_o;
	logic rx_valid_o;
	logic done_o;
	logic host_cont;
	logic dev_cont;
	logic [7:0] mem_addr;
	logic [7:0] mem_data;
	sfr_dev_st_t dev_phase;
	int failures = 0;
	int num_checks = 0;

	// ----------------------------------------------------------------
	// clock, ends and checker
	// ----------------------------------------------------------------
	always #50 mclk_i = ~mclk_i;

	// combinational array stand-in, follows the address in the link domain
	assign mem_data = mem_addr ^ 8'h5a;

	sfr_link_if lnk();

	sfr_host_end #(.LEN_W(16)) i_sfr_host_end (.link(lnk), .mclk_i(mclk_i), .nrst_i(nrst_i),
		.start_i(start_i), .op_i(op_i), .addr_i(addr_i), .mode_i(mode_i), .len_i(len_i),
		.hold_req_i(hold_req_i), .ready_o(ready_o), .rx_data_o(rx_data_o),
		.rx_valid_o(rx_valid_o), .done_o(done_o), .cont_mode_o(host_cont));

	sfr_dev_end #(.AW(8)) i_sfr_dev_end (.link(lnk), .nrst_i(nrst_i), .wip_i(wip_i),
		.mem_data_i(mem_data), .mem_addr_o(mem_addr), .cont_mode_o(dev_cont),
		.phase_o(dev_phase));

	sfr_link_checker i_sfr_link_checker (.mclk_i(mclk_i), .nrst_i(nrst_i), .wip_i(wip_i),
		.sck(lnk.sck), .cs_n(lnk.cs_n), .hold_n(lnk.hold_n), .h_io_o(lnk.h_io_o),
		.h_io_oe(lnk.h_io_oe), .d_io_o(lnk.d_io_o), .d_io_oe(lnk.d_io_oe));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one request; busy means the device must stay silent, so io reads as pull-up
	task automatic do_read(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
			input logic [15:0] n, input logic busy, input int hold_at);
		logic [7:0] exp;
		logic [15:0] got;
		int k;
		got = 16'h0000;
		@(negedge mclk_i);
		check("ready_o idle", 8'h01, {7'h00, ready_o});
		start_i = 1'b1;
		op_i = op;
		addr_i = a;
		mode_i = m;
		len_i = n;
		@(negedge mclk_i);
		start_i = 1'b0;
		check("ready_o busy", 8'h00, {7'h00, ready_o});
		for (k = 0; k < 3000 && done_o !== 1'b1; k++) begin
			hold_req_i = (hold_at > 0) && (k >= hold_at) && (k < hold_at + 100);
			// by now the opcode is long in, so a refused frame sits in the ignore state
			if (busy && k == 100) begin
				check("phase_o ignore", {5'h00, DS_IGNORE}, {5'h00, dev_phase});
			end
			if (rx_valid_o === 1'b1) begin
				exp = busy ? 8'hff : ((a[7:0] + got[7:0]) ^ 8'h5a);
				check("rx_data_o", exp, rx_data_o);
				got++;
			end
			@(negedge mclk_i);
		end
		if (k == 3000) begin
			failures++;
			$display("CHECK FAILED done_o expected 1 seen %b", done_o);
			end_sim();
		end
		check("byte count", n[7:0], got[7:0]);
		// select is high again, so the device frame must be back at the opcode
		check("phase_o idle", {5'h00, DS_CMD}, {5'h00, dev_phase});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// every read kind from a high address with junk in the ignored upper bits
	task automatic t_each_read();
		logic [7:0] ops [4];
		ops = '{SFR_OP_READ, SFR_OP_FAST, SFR_OP_DUAL_OUT, SFR_OP_DUAL_IO};
		for (int i = 0; i < 4; i++) begin
			do_read(ops[i], 24'hc3a5fe, 8'h00, 16'h0003, 1'b0, 0);
		end
	endtask

	task automatic t_back_to_back();
		do_read(SFR_OP_FAST, 24'h000010, 8'h00, 16'h0001, 1'b0, 0);
		do_read(SFR_OP_READ, 24'h000020, 8'h00, 16'h0002, 1'b0, 0);
		// an opcode the device does not serve leaves the lines to the pull-up
		do_read(8'h77, 24'h000030, 8'h00, 16'h0001, 1'b1, 0);
	endtask

	// pause lands inside the first data byte of the fast read, then inside the address phase of the dual-io read
	task automatic t_pause();
		do_read(SFR_OP_FAST, 24'h000050, 8'h00, 16'h0002, 1'b0, 180);
		do_read(SFR_OP_DUAL_IO, 24'h000060, 8'h00, 16'h0002, 1'b0, 60);
	endtask

	task automatic t_cont();
		do_read(SFR_OP_DUAL_IO, 24'h000040, 8'ha5, 16'h0002, 1'b0, 0);
		check("host cont", 8'h01, {7'h00, host_cont});
		check("dev cont", 8'h01, {7'h00, dev_cont});
		do_read(SFR_OP_READ, 24'h000080, 8'ha0, 16'h0002, 1'b0, 0);
		check("dev cont", 8'h01, {7'h00, dev_cont});
		do_read(SFR_OP_DUAL_IO, 24'h0000c0, 8'h50, 16'h0002, 1'b0, 0);
		check("dev cont", 8'h00, {7'h00, dev_cont});
		check("host cont", 8'h00, {7'h00, host_cont});
		do_read(SFR_OP_READ, 24'h000011, 8'h00, 16'h0001, 1'b0, 0);
	endtask

	// busy device ignores every read kind, then serves again once idle
	task automatic t_busy();
		logic [7:0] ops [4];
		ops = '{SFR_OP_READ, SFR_OP_FAST, SFR_OP_DUAL_OUT, SFR_OP_DUAL_IO};
		wip_i = 1'b1;
		repeat (20) @(negedge mclk_i);
		for (int i = 0; i < 4; i++) begin
			do_read(ops[i], 24'h000033, 8'h00, 16'h0001, 1'b1, 0);
		end
		wip_i = 1'b0;
		repeat (20) @(negedge mclk_i);
		do_read(SFR_OP_DUAL_OUT, 24'h000033, 8'h00, 16'h0002, 1'b0, 0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(negedge mclk_i);
		nrst_i = 1'b1;
		t_each_read();
		t_back_to_back();
		t_pause();
		t_cont();
		t_busy();
		end_sim();
	end
endmodule
